// >>> logic/tw_params.svh
// Constants of the two-wire EEPROM bit layer
`ifndef TW_PARAMS_SVH
`define TW_PARAMS_SVH

// System clock
`define TW_SYS_PERIOD_NS  20
// Least serial clock period made by the host
`define TW_SCL_PERIOD_NS  5000
// Least quarter of a serial clock period, in system cycles
`define TW_QTR_CYC        ((`TW_SCL_PERIOD_NS / 4 + `TW_SYS_PERIOD_NS - 1) / `TW_SYS_PERIOD_NS)
`define TW_QTR_W          6
// Least wait after power-up before the first command
`define TW_PUP_US         100
`define TW_PUP_CYC        ((`TW_PUP_US * 1000 + `TW_SYS_PERIOD_NS - 1) / `TW_SYS_PERIOD_NS)
`define TW_PUP_W          13
// Spike length that the input filter removes
`define TW_SPIKE_NS       50
// Byte framing
`define TW_BIT_W          4
`define TW_LAST_DATA_BIT  4'h7
`define TW_ACK_SLOT       4'h8
`define TW_BYTE_W         8
// Buffering
`define TW_FIFO_DEPTH     4
// Byte sent when nothing is queued: all ones leaves the line released
`define TW_TX_IDLE_BYTE   8'hff

`endif

// >>> logic/tw_pkg.sv
// Types of the two-wire EEPROM bit layer
package tw_pkg;

	typedef enum logic [2:0] {
		TW_D_STBY = 3'b001,
		TW_D_RX   = 3'b010,
		TW_D_TX   = 3'b100
	} tw_dev_state_t;

	typedef enum logic [4:0] {
		TW_H_WAIT  = 5'b00001,
		TW_H_IDLE  = 5'b00010,
		TW_H_START = 5'b00100,
		TW_H_BIT   = 5'b01000,
		TW_H_STOP  = 5'b10000
	} tw_host_state_t;

	typedef enum logic [1:0] {
		TW_CMD_START = 2'h0,
		TW_CMD_STOP  = 2'h1,
		TW_CMD_WRITE = 2'h2,
		TW_CMD_READ  = 2'h3
	} tw_cmd_t;

endpackage

// >>> logic/tw_link_if.sv
// Two-wire link between host and device ends
`timescale 1ns/1ps
interface tw_link_if;
	logic scl;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;

	// Open-drain data line with pull-up
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (output scl, output host_sda_oe, input sda);
	modport dev  (input scl, input sda, output dev_sda_oe);
endinterface

// >>> logic/tw_dev_end.sv
// Device end of the two-wire link with its receive and send FIFOs
`timescale 1ns/1ps
`include "tw_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Dual-clock FIFO with gray-coded pointers
module tw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Write side
	input  wire logic             wr_clk_i,
	input  wire logic             wr_rstn_i,
	input  wire logic             wr_valid_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  wr_ready_o,
	// Read side
	input  wire logic             rd_clk_i,
	input  wire logic             rd_rstn_i,
	input  wire logic             rd_ready_i,
	output logic                  rd_valid_o,
	output logic      [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin;
	logic [AW:0]      wgray;
	logic [AW:0]      rbin;
	logic [AW:0]      rgray;
	logic [AW:0]      rg_s1;
	logic [AW:0]      rg_s2;
	logic [AW:0]      wg_s1;
	logic [AW:0]      wg_s2;
	logic [AW:0]      next_wbin;
	logic [AW:0]      next_rbin;
	logic             wr_fire;
	logic             rd_fire;

	assign wr_fire   = wr_valid_i & wr_ready_o;
	assign rd_fire   = rd_valid_o & rd_ready_i;
	assign next_wbin = wbin + (AW+1)'(wr_fire);
	assign next_rbin = rbin + (AW+1)'(rd_fire);
	assign rd_data_o = mem[rbin[AW-1:0]];

	always_ff @(posedge wr_clk_i) begin
		if (wr_fire) begin
			mem[wbin[AW-1:0]] <= wr_data_i;
		end
	end

	// Write pointer and full
	always_ff @(posedge wr_clk_i) begin
		if (!wr_rstn_i) begin
			wbin       <= '0;
			wgray      <= '0;
			rg_s1      <= '0;
			rg_s2      <= '0;
			wr_ready_o <= 1'b0;
		end else begin
			wbin       <= next_wbin;
			wgray      <= bin2gray(next_wbin);
			rg_s1      <= rgray;
			rg_s2      <= rg_s1;
			wr_ready_o <= bin2gray(next_wbin) != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]};
		end
	end

	// Read pointer and empty
	always_ff @(posedge rd_clk_i) begin
		if (!rd_rstn_i) begin
			rbin       <= '0;
			rgray      <= '0;
			wg_s1      <= '0;
			wg_s2      <= '0;
			rd_valid_o <= 1'b0;
		end else begin
			rbin       <= next_rbin;
			rgray      <= bin2gray(next_rbin);
			wg_s1      <= wgray;
			wg_s2      <= wg_s1;
			rd_valid_o <= bin2gray(next_rbin) != wg_s2;
		end
	end
endmodule // tw_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Sample on clock rise, drive after fall
// - Bytes travel most significant bit first
// - Ninth clock carries acknowledge bit
// - Master clocks each byte without gaps
// - Data changes only while clock low
// - Data change while clock high is framing
// - No limit on bytes per transfer
// - Idle only when clock and data high
// - Device only answers, never starts traffic
// - Ignore bus in reset, then standby
// - Master waits 100 us after power-up
// - Filter spikes up to 50 ns
// - Transmitter releases, receiver pulls low for ack
// - Start is fall, stop is rise
// - Release data line after master no-acknowledge
module tw_dev_end
	import tw_pkg::*;
(
	// Clocks and reset
	input  wire logic       link_clk_i,
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// Two-wire link
	tw_link_if.dev          bus,
	// Received bytes
	input  wire logic       rx_ready_i,
	output logic            rx_valid_o,
	output logic      [7:0] rx_data_o,
	output logic            rx_first_o,
	// Bytes to send
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o
);
	tw_dev_state_t              st;
	logic                       link_rst_s1;
	logic                       link_rstn;
	logic [2:0]                 scl_sh;
	logic [2:0]                 sda_sh;
	logic                       scl_f;
	logic                       sda_f;
	logic                       scl_d;
	logic                       sda_d;
	logic                       scl_rise;
	logic                       scl_fall;
	logic                       start_ev;
	logic                       stop_ev;
	logic [`TW_BIT_W-1:0]       bitn;
	logic [`TW_BYTE_W-1:0]      sh;
	logic                       first;
	logic                       ack_pend;
	logic                       sda_oe;
	logic                       rx_wr_valid;
	logic [`TW_BYTE_W:0]        rx_wr_data;
	logic                       rx_wr_ready;
	logic                       rx_rd_valid;
	logic                       rx_rd_ready;
	logic [`TW_BYTE_W:0]        rx_rd_data;
	logic                       tx_rd_valid;
	logic                       tx_rd_ready;
	logic [`TW_BYTE_W-1:0]      tx_rd_data;
	logic [`TW_BYTE_W-1:0]      tx_byte;

	////////////////////////////////////////////////////////////////////////////
	// Link-domain reset, held while the system reset is low
	always_ff @(posedge link_clk_i) begin
		link_rst_s1 <= rstn_i;
		link_rstn   <= link_rst_s1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and spike filter, shorter than one link period
	always_ff @(posedge link_clk_i) begin
		if (!link_rstn) begin
			scl_sh <= 3'h7;
			sda_sh <= 3'h7;
			scl_f  <= 1'b1;
			sda_f  <= 1'b1;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_sh <= {scl_sh[1:0], bus.scl};
			sda_sh <= {sda_sh[1:0], bus.sda};
			if (scl_sh[2] == scl_sh[1]) begin
				scl_f <= scl_sh[1];
			end
			if (sda_sh[2] == sda_sh[1]) begin
				sda_f <= sda_sh[1];
			end
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_d;
	assign scl_fall = ~scl_f & scl_d;
	assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
	assign stop_ev  = scl_f & scl_d & ~sda_d & sda_f;

	////////////////////////////////////////////////////////////////////////////
	// Framing state and bit counter
	always_ff @(posedge link_clk_i) begin
		if (!link_rstn) begin
			st    <= TW_D_STBY;
			bitn  <= '0;
			first <= 1'b0;
		end else if (start_ev) begin
			st    <= TW_D_RX;
			bitn  <= '0;
			first <= 1'b1;
		end else if (stop_ev) begin
			st <= TW_D_STBY;
		end else if (scl_rise && st != TW_D_STBY) begin
			if (bitn == `TW_ACK_SLOT) begin
				bitn  <= '0;
				first <= 1'b0;
				if (st == TW_D_TX && sda_f) begin
					st <= TW_D_STBY;
				end else if (st == TW_D_RX && first && sh[0]) begin
					st <= TW_D_TX;
				end
			end else begin
				bitn <= bitn + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift register and open-drain data drive
	assign tx_byte     = tx_rd_valid ? tx_rd_data : `TW_TX_IDLE_BYTE;
	assign tx_rd_ready = (st == TW_D_TX) & scl_fall & (bitn == '0) & ~start_ev & ~stop_ev;

	always_ff @(posedge link_clk_i) begin
		if (!link_rstn) begin
			sh     <= '0;
			sda_oe <= 1'b0;
		end else if (start_ev || stop_ev) begin
			sda_oe <= 1'b0;
		end else if (st == TW_D_RX) begin
			if (scl_rise && bitn != `TW_ACK_SLOT) begin
				sh <= {sh[6:0], sda_f};
			end
			if (scl_fall) begin
				sda_oe <= (bitn == `TW_ACK_SLOT) & ack_pend;
			end
		end else if (st == TW_D_TX) begin
			if (scl_fall) begin
				if (bitn == '0) begin
					sda_oe <= ~tx_byte[7];
					sh     <= {tx_byte[6:0], 1'b0};
				end else if (bitn == `TW_ACK_SLOT) begin
					sda_oe <= 1'b0;
				end else begin
					sda_oe <= ~sh[7];
					sh     <= {sh[6:0], 1'b0};
				end
			end
		end else begin
			sda_oe <= 1'b0;
		end
	end

	assign bus.dev_sda_oe = sda_oe;

	////////////////////////////////////////////////////////////////////////////
	// Push each received byte; acknowledge only if the FIFO took it
	always_ff @(posedge link_clk_i) begin
		if (!link_rstn) begin
			rx_wr_valid <= 1'b0;
			rx_wr_data  <= '0;
			ack_pend    <= 1'b0;
		end else begin
			rx_wr_valid <= 1'b0;
			if (st == TW_D_RX && scl_rise && bitn == `TW_LAST_DATA_BIT && !start_ev && !stop_ev) begin
				rx_wr_valid <= 1'b1;
				rx_wr_data  <= {first, sh[6:0], sda_f};
				ack_pend    <= rx_wr_ready;
			end
		end
	end

	tw_fifo #(.WIDTH(`TW_BYTE_W + 1), .DEPTH(`TW_FIFO_DEPTH)) u_rx_fifo (
		.wr_clk_i   (link_clk_i),
		.wr_rstn_i  (link_rstn),
		.wr_valid_i (rx_wr_valid),
		.wr_data_i  (rx_wr_data),
		.wr_ready_o (rx_wr_ready),
		.rd_clk_i   (sys_clk_i),
		.rd_rstn_i  (rstn_i),
		.rd_ready_i (rx_rd_ready),
		.rd_valid_o (rx_rd_valid),
		.rd_data_o  (rx_rd_data)
	);

	tw_fifo #(.WIDTH(`TW_BYTE_W), .DEPTH(`TW_FIFO_DEPTH)) u_tx_fifo (
		.wr_clk_i   (sys_clk_i),
		.wr_rstn_i  (rstn_i),
		.wr_valid_i (tx_valid_i),
		.wr_data_i  (tx_data_i),
		.wr_ready_o (tx_ready_o),
		.rd_clk_i   (link_clk_i),
		.rd_rstn_i  (link_rstn),
		.rd_ready_i (tx_rd_ready),
		.rd_valid_o (tx_rd_valid),
		.rd_data_o  (tx_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Registered output stage of received bytes
	assign rx_rd_ready = ~rx_valid_o | rx_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			rx_valid_o <= 1'b0;
			rx_data_o  <= '0;
			rx_first_o <= 1'b0;
		end else if (rx_rd_valid && rx_rd_ready) begin
			rx_valid_o <= 1'b1;
			rx_first_o <= rx_rd_data[`TW_BYTE_W];
			rx_data_o  <= rx_rd_data[`TW_BYTE_W-1:0];
		end else if (rx_ready_i) begin
			rx_valid_o <= 1'b0;
		end
	end
endmodule // tw_dev_end

// >>> logic/tw_host_end.sv
// Host end of the two-wire link
`timescale 1ns/1ps
`include "tw_params.svh"

module tw_host_end
	import tw_pkg::*;
#(
	parameter int unsigned PUP_CYC = `TW_PUP_CYC
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// Two-wire link
	tw_link_if.host         bus,
	// Commands
	input  wire logic       cmd_valid_i,
	input  wire tw_cmd_t    cmd_i,
	input  wire logic [7:0] cmd_data_i,
	input  wire logic       cmd_ack_i,
	output logic            cmd_ready_o,
	// Answers
	output logic            rsp_valid_o,
	output logic      [7:0] rsp_data_o,
	output logic            rsp_nack_o
);
	tw_host_state_t          st;
	logic [`TW_PUP_W-1:0]    pup;
	logic [`TW_QTR_W-1:0]    tmr;
	logic [1:0]              q;
	logic [`TW_BIT_W-1:0]    bitn;
	logic [`TW_BYTE_W-1:0]   sh;
	logic                    is_rd;
	logic                    ack_bit;
	logic                    scl;
	logic                    oe;
	logic                    sda_s1;
	logic                    sda_s2;
	logic                    qtr_start;
	logic                    qtr_end;

	assign qtr_start       = tmr == '0;
	assign qtr_end         = tmr == `TW_QTR_W'(`TW_QTR_CYC - 1);
	assign bus.scl         = scl;
	assign bus.host_sda_oe = oe;

	////////////////////////////////////////////////////////////////////////////
	// Data line synchroniser
	always_ff @(posedge sys_clk_i) begin
		sda_s1 <= bus.sda;
		sda_s2 <= sda_s1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Quarter timer
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || st == TW_H_IDLE || st == TW_H_WAIT) begin
			tmr <= '0;
			q   <= '0;
		end else if (qtr_end) begin
			tmr <= '0;
			q   <= q + 2'h1;
		end else begin
			tmr <= tmr + `TW_QTR_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			st          <= TW_H_WAIT;
			pup         <= '0;
			bitn        <= '0;
			sh          <= '0;
			is_rd       <= 1'b0;
			ack_bit     <= 1'b0;
			scl         <= 1'b1;
			oe          <= 1'b0;
			cmd_ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= '0;
			rsp_nack_o  <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			case (st)
				TW_H_WAIT: begin
					if (pup == `TW_PUP_W'(PUP_CYC - 1)) begin
						st          <= TW_H_IDLE;
						cmd_ready_o <= 1'b1;
					end else begin
						pup <= pup + `TW_PUP_W'(1);
					end
				end
				TW_H_IDLE: begin
					if (cmd_valid_i) begin
						cmd_ready_o <= 1'b0;
						bitn        <= '0;
						case (cmd_i)
							TW_CMD_START: st <= TW_H_START;
							TW_CMD_STOP:  st <= TW_H_STOP;
							TW_CMD_WRITE: begin
								st    <= TW_H_BIT;
								sh    <= cmd_data_i;
								is_rd <= 1'b0;
							end
							default: begin
								st      <= TW_H_BIT;
								sh      <= '0;
								is_rd   <= 1'b1;
								ack_bit <= cmd_ack_i;
							end
						endcase
					end
				end
				TW_H_START: begin
					if (qtr_start) begin
						case (q)
							2'h0: scl <= 1'b0;
							2'h1: oe  <= 1'b0;
							2'h2: scl <= 1'b1;
							default: oe <= 1'b1;
						endcase
					end
					if (qtr_end && q == 2'h3) begin
						st          <= TW_H_IDLE;
						cmd_ready_o <= 1'b1;
					end
				end
				TW_H_STOP: begin
					if (qtr_start) begin
						case (q)
							2'h0: scl <= 1'b0;
							2'h1: oe  <= 1'b1;
							2'h2: scl <= 1'b1;
							default: oe <= 1'b0;
						endcase
					end
					if (qtr_end && q == 2'h3) begin
						st          <= TW_H_IDLE;
						cmd_ready_o <= 1'b1;
					end
				end
				TW_H_BIT: begin
					if (qtr_start) begin
						case (q)
							2'h0: scl <= 1'b0;
							2'h1: begin
								if (bitn == `TW_ACK_SLOT) begin
									oe <= is_rd & ack_bit;
								end else if (is_rd) begin
									oe <= 1'b0;
								end else begin
									oe <= ~sh[7];
									sh <= {sh[6:0], 1'b0};
								end
							end
							2'h2: scl <= 1'b1;
							default: begin
								if (bitn != `TW_ACK_SLOT && is_rd) begin
									sh <= {sh[6:0], sda_s2};
								end
							end
						endcase
					end
					if (qtr_end && q == 2'h3) begin
						if (bitn == `TW_ACK_SLOT) begin
							st          <= TW_H_IDLE;
							cmd_ready_o <= 1'b1;
							rsp_valid_o <= 1'b1;
							rsp_data_o  <= sh;
							rsp_nack_o  <= is_rd ? ~ack_bit : sda_s2;
						end else begin
							bitn <= bitn + 4'h1;
						end
					end
				end
				default: st <= TW_H_IDLE;
			endcase
		end
	end
endmodule // tw_host_end

// >>> verification/tw_link_properties.sv
// Concurrent checks on the two-wire link
`timescale 1ns/1ps
module tw_link_properties #(
	parameter int unsigned PUP_CYC = 50
) (
	// Clocks and reset
	input  wire logic sys_clk_i,
	input  wire logic link_clk_i,
	input  wire logic rstn_i,
	// Link signals
	input  wire logic scl,
	input  wire logic host_sda_oe,
	input  wire logic dev_sda_oe,
	input  wire logic sda
);
	logic        scl_q;
	logic        sda_q;
	logic [3:0]  slot;
	logic        quiet;
	logic [15:0] pup_cnt;
	logic        frame_w;
	logic        rise_w;
	logic [4:0]  settle;
	logic        live;

	assign frame_w = scl & scl_q & (sda ^ sda_q);
	assign rise_w  = scl & ~scl_q;
	assign live    = settle == 5'h1f;

	// Link-side reset lags the system reset by a few link clocks
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			settle <= 5'h0;
		end else if (!live) begin
			settle <= settle + 5'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Line history
	always_ff @(posedge sys_clk_i) begin
		scl_q <= scl;
		sda_q <= sda;
	end

	// Clock rises since the last start or stop, modulo nine
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || frame_w) begin
			slot <= 4'h0;
		end else if (rise_w) begin
			slot <= (slot == 4'h8) ? 4'h0 : slot + 4'h1;
		end
	end

	// Set by a high ack slot, cleared by the next start
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || (frame_w && !sda)) begin
			quiet <= 1'b0;
		end else if (rise_w && slot == 4'h8 && sda) begin
			quiet <= 1'b1;
		end
	end

	// Cycles since reset release, held once it reaches PUP_CYC
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			pup_cnt <= 16'h0;
		end else if (pup_cnt < 16'(PUP_CYC)) begin
			pup_cnt <= pup_cnt + 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	dev_chg_low_a: assert property (@(posedge link_clk_i) disable iff (!live)
		$changed(dev_sda_oe) |-> !scl) else $error("device data moved with clock high");
	host_chg_low_a: assert property (@(posedge sys_clk_i) disable iff (!live)
		$changed(host_sda_oe) && scl |-> slot == 4'h1) else $error("host data moved with clock high");
	dev_hi_still_a: assert property (@(posedge sys_clk_i) disable iff (!live)
		scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe)) else $error("data moved by device in high");
	frame_nine_a: assert property (@(posedge sys_clk_i) disable iff (!live)
		scl && $past(scl) && $rose(sda) |-> slot == 4'h1) else $error("stop not on a byte boundary");
	start_host_a: assert property (@(posedge sys_clk_i) disable iff (!live)
		scl && $past(scl) && $fell(sda) |-> host_sda_oe && slot == 4'h1) else $error("start not made by host");
	nack_rel_a: assert property (@(posedge sys_clk_i) disable iff (!live)
		quiet |-> !dev_sda_oe) else $error("device drives after no-acknowledge");
	pup_wait_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pup_cnt < 16'(PUP_CYC) |-> scl && !host_sda_oe) else $error("host active during power-up wait");
	reset_idle_a: assert property (@(posedge sys_clk_i) disable iff (!live)
		$rose(live) |-> scl && sda && !dev_sda_oe) else $error("link not idle after reset");

	start_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) scl && $past(scl) && $fell(sda));
	stop_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) scl && $past(scl) && $rose(sda));
	ack_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(dev_sda_oe));
	quiet_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(quiet));
endmodule // tw_link_properties

// >>> verification/twowire_eeprom_slave_bit_layer_tb.sv
// Testbench joining host and device ends over the link
`timescale 1ns/1ps
module twowire_eeprom_slave_bit_layer_tb;
	import tw_pkg::*;

	localparam int unsigned PUP = 50;
	logic       sys_clk_i;
	logic       link_clk_i;
	logic       rstn_i;
	logic       cmd_valid, cmd_ack, cmd_ready, rsp_valid, rsp_nack;
	tw_cmd_t    cmd;
	logic [7:0] cmd_data, rsp_data, rx_data, tx_data;
	logic       rx_ready, rx_valid, rx_first, tx_valid, tx_ready;
	logic [8:0] wire_sh;
	int         n_errors;
	int         checks_done;

	tw_link_if link ();

	tw_host_end #(.PUP_CYC(PUP)) u_tw_host_end (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus(link),
		.cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_data_i(cmd_data), .cmd_ack_i(cmd_ack),
		.cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));

	tw_dev_end u_tw_dev_end (.link_clk_i(link_clk_i), .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus(link),
		.rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_first_o(rx_first),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));

	tw_link_properties #(.PUP_CYC(PUP)) u_tw_link_properties (.sys_clk_i(sys_clk_i), .link_clk_i(link_clk_i),
		.rstn_i(rstn_i), .scl(link.scl), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
		.sda(link.sda));

	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		link_clk_i = 1'b0;
		#37;
		forever #62.5 link_clk_i = ~link_clk_i;
	end

	// Bits on the wire at each clock rise
	always @(posedge link.scl) begin
		wire_sh <= {wire_sh[7:0], link.sda};
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wait_hi(ref logic sig, input string nm);
		for (int i = 0; i < 4000; i++) begin
			@(negedge sys_clk_i);
			if (sig === 1'b1) begin
				return;
			end
		end
		chk(nm, 16'h0, 16'h1);
		wrap_up();
	endtask

	// For READ, d is the byte expected back
	task automatic host_op(input tw_cmd_t c, input logic [7:0] d, input logic a, input logic nk);
		wait_hi(cmd_ready, "cmd_ready");
		cmd = c;
		cmd_data = d;
		cmd_ack = a;
		cmd_valid = 1'b1;
		@(negedge sys_clk_i);
		cmd_valid = 1'b0;
		if (c == TW_CMD_WRITE || c == TW_CMD_READ) begin
			wait_hi(rsp_valid, "rsp_valid");
			if (c == TW_CMD_READ) begin
				chk("rsp_data", 16'(rsp_data), 16'(d));
			end
			chk("wire_bits", 16'(wire_sh), 16'({d, nk}));
			chk("rsp_nack", 16'(rsp_nack), 16'(nk));
		end
	endtask

	task automatic dev_pop(input logic [7:0] d, input logic f);
		wait_hi(rx_valid, "rx_valid");
		chk("rx_data", 16'(rx_data), 16'(d));
		chk("rx_first", 16'(rx_first), 16'(f));
		rx_ready = 1'b1;
		@(negedge sys_clk_i);
		rx_ready = 1'b0;
	endtask

	task automatic dev_push(input logic [7:0] d);
		wait_hi(tx_ready, "tx_ready");
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge sys_clk_i);
		tx_valid = 1'b0;
	endtask

	task automatic idle_chk();
		wait_hi(cmd_ready, "cmd_ready");
		chk("idle", 16'({link.scl, link.sda, link.dev_sda_oe}), 16'h6);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] wr_tab [6];
		int         i;
		wr_tab = '{8'ha4, 8'h5a, 8'h00, 8'hff, 8'h3c, 8'h96};
		n_errors = 0;
		checks_done = 0;
		rstn_i = 1'b0;
		cmd_valid = 1'b0;
		cmd = TW_CMD_START;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		rx_ready = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		repeat (12) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 1000) begin
			@(negedge sys_clk_i);
			i++;
		end
		chk("pup_wait", 16'(i), 16'(PUP));
		chk("tx_ready", 16'(tx_ready), 16'h1);
		// Six writes: output stage plus four queued, the sixth finds the buffer full
		host_op(TW_CMD_START, 8'h00, 1'b0, 1'b0);
		for (i = 0; i < 6; i++) begin
			host_op(TW_CMD_WRITE, wr_tab[i], 1'b0, i == 5);
		end
		host_op(TW_CMD_STOP, 8'h00, 1'b0, 1'b0);
		idle_chk();
		for (i = 0; i < 5; i++) begin
			dev_pop(wr_tab[i], i == 0);
		end
		repeat (8) @(negedge sys_clk_i);
		chk("rx_empty", 16'(rx_valid), 16'h0);
		// Write, repeated start, then read past the queued bytes
		dev_push(8'hc3);
		dev_push(8'h81);
		host_op(TW_CMD_START, 8'h00, 1'b0, 1'b0);
		host_op(TW_CMD_WRITE, 8'ha4, 1'b0, 1'b0);
		host_op(TW_CMD_WRITE, 8'h77, 1'b0, 1'b0);
		host_op(TW_CMD_START, 8'h00, 1'b0, 1'b0);
		host_op(TW_CMD_WRITE, 8'ha5, 1'b0, 1'b0);
		host_op(TW_CMD_READ, 8'hc3, 1'b1, 1'b0);
		host_op(TW_CMD_READ, 8'h81, 1'b1, 1'b0);
		host_op(TW_CMD_READ, 8'hff, 1'b0, 1'b1);
		host_op(TW_CMD_STOP, 8'h00, 1'b0, 1'b0);
		idle_chk();
		dev_pop(8'ha4, 1'b1);
		dev_pop(8'h77, 1'b0);
		dev_pop(8'ha5, 1'b1);
		// Fill the send buffer with four bytes, check that it refuses, then drain it over the link
		for (i = 0; i < 4; i++) begin
			dev_push(8'h11 + 8'(i));
		end
		repeat (3) @(negedge sys_clk_i);
		chk("tx_full", 16'(tx_ready), 16'h0);
		host_op(TW_CMD_START, 8'h00, 1'b0, 1'b0);
		host_op(TW_CMD_WRITE, 8'ha5, 1'b0, 1'b0);
		for (i = 0; i < 4; i++) begin
			host_op(TW_CMD_READ, 8'h11 + 8'(i), i != 3, i == 3);
		end
		host_op(TW_CMD_STOP, 8'h00, 1'b0, 1'b0);
		idle_chk();
		dev_pop(8'ha5, 1'b1);
		chk("tx_free", 16'(tx_ready), 16'h1);
		wrap_up();
	end
endmodule // twowire_eeprom_slave_bit_layer_tb
